//--- include/qcs_pkg.sv
// Purpose: shared constants and carriers for the quad channel glue
// Assumes: four channels, eight-bit host bus
// Notes:   channel index 0..3 stands for channels A..D
package qcs_pkg;

  localparam int NUM_CHAN = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int BUS_ADDR_W = 3;

  // Line status bit positions
  localparam int LSR_TX_ROOM_BIT = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;

  // Fifo control bit positions
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int FCR_BLOCK_BIT = 3;

  // Receive timeout in character times
  localparam int RX_TIMEOUT_CHARS = 4;
  localparam int CHAR_TIME_CYCLES = 8'd100;

  localparam logic [7:0] FCR_RESET = 8'h00;

  typedef struct packed {
    logic fifo_en;
    logic block_mode;
  } qcs_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] tx_count;
    logic [CNT_W-1:0] rx_count;
    logic [CNT_W-1:0] tx_trigger;
    logic [CNT_W-1:0] rx_trigger;
    logic             tx_shift_busy;
    logic             rx_char_event;
  } qcs_fifo_state_t;

  typedef struct packed {
    logic int_tx;
    logic int_rx;
    logic tx_ready_n;
    logic rx_ready_n;
    logic tx_room;
    logic tx_empty;
  } qcs_pins_t;

endpackage : qcs_pkg

//--- src/qcs_chan_status.sv
// Purpose: per-channel interrupt, ready pins and line status bits
// Assumes: fifo counts come from the channel core on i_clk
// Notes:   ready outputs are active low
`timescale 1ns/1ps
module qcs_chan_status #(
  parameter int TIMEOUT_CYCLES = qcs_pkg::RX_TIMEOUT_CHARS *
                                 qcs_pkg::CHAR_TIME_CYCLES
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire qcs_pkg::qcs_mode_t      i_mode,
  input  wire qcs_pkg::qcs_fifo_state_t i_fifo,
  output logic                         o_timeout,
  output qcs_pkg::qcs_pins_t           o_pins
);

  initial begin
    // Counter is sixteen bits wide
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 65536) begin
      $error("TIMEOUT_CYCLES must be 1 to 65536");
    end
  end

  localparam logic [qcs_pkg::CNT_W-1:0] FULL_CNT =
    qcs_pkg::CNT_W'(qcs_pkg::FIFO_DEPTH);

  logic [15:0]        to_cnt_reg;
  logic [15:0]        to_cnt_next;
  logic               timeout_reg;
  logic               timeout_next;
  logic               rxr_reg;
  logic               rxr_next;
  qcs_pkg::qcs_pins_t pins_reg;
  qcs_pkg::qcs_pins_t pins_next;
  logic               rx_any;
  logic               tx_any;

  assign rx_any = (i_fifo.rx_count != '0);
  assign tx_any = (i_fifo.tx_count != '0);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    to_cnt_next = to_cnt_reg;
    timeout_next = timeout_reg;
    // (RULE22) Idle receive timeout
    if (!rx_any || i_fifo.rx_char_event ||
        i_fifo.rx_count >= i_fifo.rx_trigger) begin
      to_cnt_next = '0;
      timeout_next = 1'b0;
    end else if (to_cnt_reg == 16'(TIMEOUT_CYCLES - 1)) begin
      timeout_next = 1'b1;
    end else begin
      to_cnt_next = to_cnt_reg + 16'h0001;
    end
    // (RULE17) Block mode receive latch
    rxr_next = rxr_reg;
    if (!rx_any) begin
      rxr_next = 1'b1;
    end else if (i_fifo.rx_count >= i_fifo.rx_trigger || timeout_reg) begin
      rxr_next = 1'b0;
    end
    pins_next = '0;
    if (!i_mode.fifo_en) begin
      // (RULE9) Holding register empty
      pins_next.int_tx = !tx_any;
      // (RULE11) One byte held
      pins_next.int_rx = rx_any;
      // (RULE15) Receive ready low
      pins_next.rx_ready_n = !rx_any;
      // (RULE18) Transmit ready low
      pins_next.tx_ready_n = tx_any;
    end else begin
      // (RULE10) Transmit trigger level
      pins_next.int_tx = !(i_fifo.tx_count > i_fifo.tx_trigger);
      // (RULE12) Receive trigger level
      pins_next.int_rx = (i_fifo.rx_count > i_fifo.rx_trigger);
      // (RULE13) Single versus block
      if (!i_mode.block_mode) begin
        // (RULE16) Any byte ready
        pins_next.rx_ready_n = !rx_any;
        // (RULE19) Empty fifo ready
        pins_next.tx_ready_n = tx_any;
      end else begin
        pins_next.rx_ready_n = rxr_next;
        // (RULE20) Free location ready
        pins_next.tx_ready_n = (i_fifo.tx_count >= FULL_CNT);
      end
    end
    // (RULE14) Line status room/empty
    pins_next.tx_room = i_mode.fifo_en ? (i_fifo.tx_count < FULL_CNT)
                                       : !tx_any;
    pins_next.tx_empty = !tx_any && !i_fifo.tx_shift_busy;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      to_cnt_reg <= '0;
      timeout_reg <= 1'b0;
      rxr_reg <= 1'b1;
      pins_reg <= 6'b00_1100;
    end else begin
      to_cnt_reg <= to_cnt_next;
      timeout_reg <= timeout_next;
      rxr_reg <= rxr_next;
      pins_reg <= pins_next;
    end
  end

  assign o_timeout = timeout_reg;
  assign o_pins = pins_reg;

endmodule : qcs_chan_status

//--- src/qcs_top.sv
// Purpose: channel decode and status pins for a four channel uart
// Assumes: bus strobes asynchronous; status core on i_clk
// Notes:   decode is combinational so no clock is needed for it
// Operation
// (RULE1) Mode high: four separate low selects
// (RULE2) All selects high: nothing selected
// (RULE3) All selects low: broadcast to all
// (RULE4) Host never reads with several selected
// (RULE5) Mode low: one select plus two bits
// (RULE6) Shared select high deselects all
// (RULE7) Address bits ignored in separate mode
// (RULE8) Each channel owns its register set
// (RULE9) No fifo: tx interrupt when empty
// (RULE10) Fifo: tx interrupt by trigger level
// (RULE11) No fifo: rx interrupt when byte held
// (RULE12) Fifo: rx interrupt above trigger
// (RULE13) Block bit selects single or block
// (RULE14) Status bits report room and empty
// (RULE15) No fifo: rx ready low when held
// (RULE16) Single mode: rx ready while nonempty
// (RULE17) Block mode: rx ready trigger/timeout latch
// (RULE18) No fifo: tx ready low when empty
// (RULE19) Single mode: tx ready when empty
// (RULE20) Block mode: tx ready while room
// (RULE21) Bus cycles need no clock
// (RULE22) Timeout after four idle characters
`timescale 1ns/1ps
module qcs_top #(
  parameter int TIMEOUT_CYCLES = qcs_pkg::RX_TIMEOUT_CHARS *
                                 qcs_pkg::CHAR_TIME_CYCLES
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_bus_mode_sep,
  input  wire logic                   i_chan_a_select_n,
  input  wire logic                   i_chan_b_select_n,
  input  wire logic                   i_chan_c_select_n,
  input  wire logic                   i_chan_d_select_n,
  input  wire logic                   i_shared_select_n,
  input  wire logic                   i_chan_addr_hi,
  input  wire logic                   i_chan_addr_lo,
  input  wire logic                   i_write_n,
  input  wire logic                   i_read_n,
  input  wire logic [qcs_pkg::NUM_CHAN-1:0] i_fcr_wr,
  input  wire logic [7:0]             i_wdata,
  input  wire qcs_pkg::qcs_fifo_state_t [qcs_pkg::NUM_CHAN-1:0] i_fifo,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_chan_sel,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_chan_wr,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_chan_rd,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_int,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_tx_ready_n,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_rx_ready_n,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_rx_timeout,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_lsr_tx_room,
  output logic [qcs_pkg::NUM_CHAN-1:0] o_lsr_tx_empty
);

  localparam int NC = qcs_pkg::NUM_CHAN;

  initial begin
    if (NC != 4) begin
      $error("decode serves exactly four channels");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pure gate decode: works with the oscillator stopped
  function automatic logic [3:0] qcs_one_hot(input logic [1:0] idx);
    logic [3:0] r;
    r = 4'h0;
    r[idx] = 1'b1;
    return r;
  endfunction : qcs_one_hot

  logic [NC-1:0] sel_sep;
  logic [NC-1:0] sel_shr;
  logic [NC-1:0] sel;
  logic          multi;

  always_comb begin
    // (RULE1) Separate select decode
    sel_sep = ~{i_chan_d_select_n, i_chan_c_select_n,
                i_chan_b_select_n, i_chan_a_select_n};
    // (RULE2) All high: none
    // (RULE3) All low: broadcast
    // (RULE5) Shared select decode
    sel_shr = qcs_one_hot({i_chan_addr_hi, i_chan_addr_lo});
    // (RULE6) Shared select gating
    if (i_shared_select_n) begin
      sel_shr = 4'h0;
    end
    // (RULE7) Address bits unused here
    sel = i_bus_mode_sep ? sel_sep : sel_shr;
  end

  // (RULE4) Reads suppressed when several selected
  assign multi = (sel != 4'h0) && ((sel & (sel - 4'h1)) != 4'h0);

  // (RULE21) Strobe-qualified transfers
  assign o_chan_sel = sel;
  assign o_chan_wr = sel & {NC{!i_write_n}};
  assign o_chan_rd = sel & {NC{!i_read_n && !multi}};

  ////////////////////////////////////////////////////////////////////////
  // Per channel state: one independent set each
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_chan
      logic               fen_reg;
      logic               fen_next;
      logic               blk_reg;
      logic               blk_next;
      qcs_pkg::qcs_mode_t mode;
      qcs_pkg::qcs_pins_t pins;

      // (RULE8) Own fifo control copy
      always_comb begin
        fen_next = fen_reg;
        blk_next = blk_reg;
        if (i_fcr_wr[g]) begin
          fen_next = i_wdata[qcs_pkg::FCR_FIFO_EN_BIT];
          blk_next = i_wdata[qcs_pkg::FCR_BLOCK_BIT];
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          fen_reg <= qcs_pkg::FCR_RESET[qcs_pkg::FCR_FIFO_EN_BIT];
          blk_reg <= qcs_pkg::FCR_RESET[qcs_pkg::FCR_BLOCK_BIT];
        end else begin
          fen_reg <= fen_next;
          blk_reg <= blk_next;
        end
      end

      assign mode.fifo_en = fen_reg;
      assign mode.block_mode = blk_reg;

      qcs_chan_status #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
      ) u_status (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_mode    (mode),
        .i_fifo    (i_fifo[g]),
        .o_timeout (o_rx_timeout[g]),
        .o_pins    (pins)
      );

      // Interrupt when either path asks for service
      assign o_int[g] = pins.int_tx | pins.int_rx;
      assign o_tx_ready_n[g] = pins.tx_ready_n;
      assign o_rx_ready_n[g] = pins.rx_ready_n;
      assign o_lsr_tx_room[g] = pins.tx_room;
      assign o_lsr_tx_empty[g] = pins.tx_empty;
    end
  endgenerate

endmodule : qcs_top

//--- tb/qcs_host_model.sv
// Purpose: host side bus model driving the select pins
// Assumes: i_sel holds one bit per channel, all four for broadcast
// Notes:   index bits follow i_sel even while deselected
`timescale 1ns/1ps
module qcs_host_model (
  input  wire logic       i_sep,
  input  wire logic [3:0] i_sel,
  input  wire logic       i_rd,
  output logic [3:0]      o_cs_n,
  output logic            o_shared_n,
  output logic [1:0]      o_addr,
  output logic            o_rd_n
);
  always_comb begin
    o_cs_n     = i_sep ? ~i_sel : 4'hF;
    o_shared_n = i_sep | ~|i_sel;
    o_addr     = {i_sel[3] | i_sel[2], i_sel[3] | i_sel[1]};
    o_rd_n     = ~(i_rd & $onehot(i_sel));
  end
endmodule : qcs_host_model

//--- tb/qcs_top_sva.sv
// Purpose: concurrent checks on decode and channel A status pins
// Assumes: channel A mode tracked from its fifo control writes
// Notes:   status checks watch channel A only, to stay small
`timescale 1ns/1ps
module qcs_top_sva (
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_bus_mode_sep,
  input wire logic       i_chan_a_select_n,
  input wire logic       i_chan_b_select_n,
  input wire logic       i_chan_c_select_n,
  input wire logic       i_chan_d_select_n,
  input wire logic       i_shared_select_n,
  input wire logic       i_chan_addr_hi,
  input wire logic       i_chan_addr_lo,
  input wire logic [3:0] i_fcr_wr,
  input wire logic [7:0] i_wdata,
  input wire qcs_pkg::qcs_fifo_state_t [3:0] i_fifo,
  input wire logic [3:0] o_chan_sel,
  input wire logic [3:0] o_chan_rd,
  input wire logic [3:0] o_int,
  input wire logic [3:0] o_tx_ready_n,
  input wire logic [3:0] o_rx_ready_n
);
  logic en_reg, en_next, blk_reg, blk_next;
  wire logic [3:0] cs_n = {i_chan_d_select_n, i_chan_c_select_n,
                           i_chan_b_select_n, i_chan_a_select_n};
  wire logic [1:0] idx = {i_chan_addr_hi, i_chan_addr_lo};
  wire logic [5:0] tx_c = i_fifo[0].tx_count;
  wire logic [5:0] rx_c = i_fifo[0].rx_count;
  wire logic [5:0] rx_t = i_fifo[0].rx_trigger;
  //////////////////////////////////////////////////////////////////
  always_comb begin
    en_next  = en_reg;
    blk_next = blk_reg;
    if (i_fcr_wr[0]) begin
      en_next  = i_wdata[qcs_pkg::FCR_FIFO_EN_BIT];
      blk_next = i_wdata[qcs_pkg::FCR_BLOCK_BIT];
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_reg  <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      en_reg  <= en_next;
      blk_reg <= blk_next;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_sep_decode: assert property (
    i_bus_mode_sep |-> o_chan_sel == ~cs_n) else $error("sep decode");
  a_shared_off: assert property (
    !i_bus_mode_sep && i_shared_select_n |-> o_chan_sel == 4'h0)
    else $error("shared deselect");
  a_shared_idx: assert property (
    !i_bus_mode_sep && !i_shared_select_n |-> o_chan_sel == 4'h1 << idx)
    else $error("shared decode");
  a_rd_refuse: assert property (
    !$onehot0(o_chan_sel) |-> o_chan_rd == 4'h0) else $error("multi rd");
  a_block_tx: assert property (
    en_reg && blk_reg |=> o_tx_ready_n[0] == ($past(tx_c) == 6'h20))
    else $error("block tx ready");
  a_rx_int: assert property (
    en_reg && rx_c > rx_t |=> o_int[0]) else $error("rx int");
  a_rx_fall: assert property (
    en_reg && blk_reg && rx_c >= rx_t && rx_c != 6'h00 |=> !o_rx_ready_n[0])
    else $error("block rx ready");
  a_rx_empty: assert property (
    en_reg && rx_c == 6'h00 |=> o_rx_ready_n[0]) else $error("rx empty");
endmodule : qcs_top_sva

bind qcs_top qcs_top_sva u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_bus_mode_sep(i_bus_mode_sep), .i_chan_a_select_n(i_chan_a_select_n),
  .i_chan_b_select_n(i_chan_b_select_n),
  .i_chan_c_select_n(i_chan_c_select_n),
  .i_chan_d_select_n(i_chan_d_select_n),
  .i_shared_select_n(i_shared_select_n), .i_chan_addr_hi(i_chan_addr_hi),
  .i_chan_addr_lo(i_chan_addr_lo), .i_fcr_wr(i_fcr_wr), .i_wdata(i_wdata),
  .i_fifo(i_fifo), .o_chan_sel(o_chan_sel), .o_chan_rd(o_chan_rd),
  .o_int(o_int), .o_tx_ready_n(o_tx_ready_n),
  .o_rx_ready_n(o_rx_ready_n));

//--- tb/qcs_top_tb_top.sv
// Purpose: directed bench for channel decode and ready pins
// Assumes: host model drives the bus pins; fifo state set here
// Notes:   short timeout parameter keeps the run brief
`timescale 1ns/1ps
module qcs_top_tb_top;
  localparam int TMO = 8;
  logic       clk, arst_n, sep, rd, shared_n, rd_n, wr_n;
  logic [3:0] c_wr, room, emp;
  logic [1:0] addr;
  logic [3:0] sel, fcr_wr, cs_n, c_sel, c_rd, int_o, txr_n, rxr_n, tmo_o;
  logic [7:0] wdata;
  qcs_pkg::qcs_fifo_state_t [3:0] fifo;
  int         n_errors, checks_done, cyc;
  qcs_host_model u_host (.i_sep(sep), .i_sel(sel), .i_rd(rd),
    .o_cs_n(cs_n), .o_shared_n(shared_n), .o_addr(addr), .o_rd_n(rd_n));
  qcs_top #(.TIMEOUT_CYCLES(TMO)) u_dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_bus_mode_sep(sep), .i_chan_a_select_n(cs_n[0]),
    .i_chan_b_select_n(cs_n[1]), .i_chan_c_select_n(cs_n[2]),
    .i_chan_d_select_n(cs_n[3]), .i_shared_select_n(shared_n),
    .i_chan_addr_hi(addr[1]), .i_chan_addr_lo(addr[0]),
    .i_write_n(wr_n), .i_read_n(rd_n), .i_fcr_wr(fcr_wr),
    .i_wdata(wdata), .i_fifo(fifo), .o_chan_sel(c_sel), .o_chan_wr(c_wr),
    .o_chan_rd(c_rd), .o_int(int_o), .o_tx_ready_n(txr_n),
    .o_rx_ready_n(rxr_n), .o_rx_timeout(tmo_o), .o_lsr_tx_room(room),
    .o_lsr_tx_empty(emp));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [5:0] tx, input logic [5:0] rx);
    @(posedge clk);
    fifo[0].tx_count <= tx;
    fifo[0].rx_count <= rx;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : put
  task automatic set_mode(input logic [7:0] v);
    @(posedge clk);
    wdata  <= v;
    fcr_wr <= 4'hF;
    @(posedge clk);
    fcr_wr <= 4'h0;
  endtask : set_mode
  task automatic t_sep();
    logic [3:0] pat [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    foreach (pat[k]) begin
      @(posedge clk);
      sep <= 1'b1;
      sel <= pat[k];
      rd  <= 1'b1;
      wr_n <= 1'b0;
      @(negedge clk);
      chk(c_sel, pat[k]);
      chk(c_wr, pat[k]);
      chk(c_rd, pat[k] == 4'hF ? 4'h0 : pat[k]);
    end
  endtask : t_sep
  task automatic t_shared();
    for (int n = 0; n < 5; n++) begin
      @(posedge clk);
      sep <= 1'b0;
      sel <= (n < 4) ? 4'h1 << n : 4'h0;
      @(negedge clk);
      chk(c_sel, (n < 4) ? 4'h1 << n : 4'h0);
    end
  endtask : t_shared
  task automatic t_nofifo();
    set_mode(8'h00);
    put(6'h00, 6'h01);
    chk(txr_n[0], 1'b0);
    chk(int_o[0], 1'b1);
    chk(rxr_n[0], 1'b0);
    chk(room[0], 1'b1);
    chk(emp[0], 1'b1);
    put(6'h01, 6'h00);
    chk(int_o[0], 1'b0);
    chk(rxr_n[0], 1'b1);
  endtask : t_nofifo
  task automatic t_single();
    set_mode(8'h01);
    put(6'h00, 6'h00);
    chk(txr_n[0], 1'b0);
    chk(rxr_n[0], 1'b1);
    put(6'h09, 6'h01);
    chk(txr_n[0], 1'b1);
    chk(int_o[0], 1'b0);
    put(6'h09, 6'h05);
    chk(int_o[0], 1'b1);
  endtask : t_single
  task automatic t_block();
    set_mode(8'h09);
    // Latch may still be low from single mode: empty it first
    put(6'h1F, 6'h00);
    chk(txr_n[0], 1'b0);
    chk(room[0], 1'b1);
    chk(emp[0], 1'b0);
    put(6'h1F, 6'h03);
    chk(rxr_n[0], 1'b1);
    put(6'h20, 6'h04);
    chk(txr_n[0], 1'b1);
    chk(room[0], 1'b0);
    put(6'h20, 6'h02);
    chk(rxr_n[0], 1'b0);
    put(6'h20, 6'h00);
    chk(rxr_n[0], 1'b1);
    put(6'h20, 6'h01);
    chk(tmo_o[0], 1'b0);
    repeat (TMO + 2) @(posedge clk);
    @(negedge clk);
    chk(tmo_o[0], 1'b1);
    chk(rxr_n[0], 1'b0);
  endtask : t_block
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {arst_n, sep, rd, sel, fcr_wr, wdata, fifo} = '0;
    fifo[0].tx_trigger = 6'h08;
    fifo[0].rx_trigger = 6'h04;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_sep();
    t_shared();
    t_nofifo();
    t_single();
    t_block();
    summarize();
  end
endmodule : qcs_top_tb_top
